//--- design/ssr_top.sv
// status byte, summary messages and service request of the instrument
`timescale 1ns/1ps
`default_nettype none
module ssr_top
	import ssr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// power-on status clear flag and saved enables
	input wire logic psc_flag,
	input wire logic [SSR_EVT_W-1:0] saved_evt_en,
	input wire logic [SSR_STB_W-1:0] saved_srq_en,
	input wire logic [SSR_HW_W-1:0] saved_hw_en,
	// command port from the message parser
	input wire logic cmd_valid,
	input wire ssr_cmd_e cmd_code,
	input wire logic [SSR_RESP_W-1:0] cmd_data,
	// query answer
	output logic resp_valid,
	output logic [SSR_RESP_W-1:0] resp_data,
	// event sources
	input wire logic [SSR_EVT_W-1:0] evt_set,
	input wire logic [SSR_HW_W-1:0] hw_set,
	input wire logic meas_done,
	input wire logic meas_start,
	input wire logic meas_clear,
	input wire logic out_buf_nonempty,
	// serial poll
	input wire logic spoll_req,
	output logic spoll_valid,
	output logic [SSR_STB_W-1:0] spoll_data,
	// addressing and interface clear pin
	input wire logic addr_talk,
	input wire logic addr_listen,
	input wire logic unaddr,
	input wire logic ifc_pin,
	output logic talk_active,
	output logic listen_active,
	// service request and status byte
	output logic srq_out,
	output logic [SSR_STB_W-1:0] status_summary_byte
);

	// ============================================================
	// state
	typedef struct packed {
		logic [SSR_EVT_W-1:0] esr;
		logic [SSR_HW_W-1:0] hardware_condition_register;
		logic measurement_done_bit;
		logic mav;
		logic rqs;
		logic talk;
		logic listen;
		logic resp_valid;
		logic [SSR_RESP_W-1:0] resp_data;
		logic spoll_valid;
		logic [SSR_STB_W-1:0] spoll_data;
		logic [SSR_STB_W-1:0] stb;
		logic por_pending;
		logic mss_d;
	} ssr_top_s;

	ssr_top_s st;
	ssr_top_s next_st;

	// ============================================================
	// enable masks
	logic [SSR_EVT_W-1:0] event_enable_mask;
	logic [SSR_STB_W-1:0] service_request_mask;
	logic [SSR_HW_W-1:0] hardware_condition_enable;
	logic restore_en;
	logic wr_evt_en;
	logic wr_srq_en;
	logic wr_hw_en;
	logic ifc_level;

	// restore saved enables only when the power-on clear flag is false
	assign restore_en = st.por_pending & ~psc_flag;
	assign wr_evt_en = cmd_valid && (cmd_code == SSR_SET_EVT_EN);
	assign wr_srq_en = cmd_valid && (cmd_code == SSR_SET_SRQ_EN);
	assign wr_hw_en = cmd_valid && (cmd_code == SSR_SET_HW_EN);

	ssr_mask_reg #(
		.W(SSR_EVT_W),
		.KEEP(SSR_EVT_KEEP)
	) u_evt_en (
		.core_clk(core_clk),
		.resetn(resetn),
		.wr_en(wr_evt_en),
		.wr_data(cmd_data),
		.restore_en(restore_en),
		.restore_data(saved_evt_en),
		.value(event_enable_mask)
	);

	ssr_mask_reg #(
		.W(SSR_STB_W),
		.KEEP(SSR_SRE_KEEP)
	) u_srq_en (
		.core_clk(core_clk),
		.resetn(resetn),
		.wr_en(wr_srq_en),
		.wr_data(cmd_data[SSR_STB_W-1:0]),
		.restore_en(restore_en),
		.restore_data(saved_srq_en),
		.value(service_request_mask)
	);

	// hardware condition enable store
	ssr_mask_reg #(
		.W(SSR_HW_W),
		.KEEP(SSR_HW_KEEP)
	) u_hw_en (
		.core_clk(core_clk),
		.resetn(resetn),
		.wr_en(wr_hw_en),
		.wr_data(cmd_data),
		.restore_en(restore_en),
		.restore_data(saved_hw_en),
		.value(hardware_condition_enable)
	);

	// interface clear pin crosses in through three stages
	ssr_sync u_ifc_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin_in(ifc_pin),
		.level(ifc_level)
	);

	// ============================================================
	// summary messages
	logic esb;
	logic hardware_summary_bit;
	logic mss;
	logic mss_rise;
	logic [SSR_STB_W-1:0] stb_base;
	logic do_cls;
	logic rd_esr;
	logic rd_hsr;

	assign do_cls = cmd_valid && (cmd_code == SSR_CLR_STATUS);
	assign rd_esr = cmd_valid && (cmd_code == SSR_GET_EVT_STAT);
	assign rd_hsr = cmd_valid && (cmd_code == SSR_GET_HW_COND);

	assign esb = |(st.esr & event_enable_mask);
	assign hardware_summary_bit = |(st.hardware_condition_register & hardware_condition_enable);

	// status byte layout, unused bits zero
	always_comb
	begin
		stb_base = SSR_STB_RST;
		stb_base[SSR_STB_HSB] = hardware_summary_bit;
		stb_base[SSR_STB_MCB] = st.measurement_done_bit;
		stb_base[SSR_STB_MAV] = st.mav;
		stb_base[SSR_STB_ESB] = esb;
	end

	// master summary over the seven other bits
	assign mss = |(stb_base & service_request_mask);
	assign mss_rise = mss & ~st.mss_d;

	// ============================================================
	// next state
	always_comb
	begin
		next_st = st;
		next_st.resp_valid = 1'b0;
		next_st.spoll_valid = 1'b0;
		next_st.por_pending = 1'b0;
		next_st.mss_d = mss;

		// clear status empties the event registers only
		if (do_cls)
		begin
			next_st.esr = SSR_EVT_RST;
			next_st.hardware_condition_register = SSR_HW_RST;
		end
		// event status read clears after answering
		if (rd_esr)
		begin
			next_st.esr = SSR_EVT_RST;
		end
		// hardware condition read clears after answering
		if (rd_hsr)
		begin
			next_st.hardware_condition_register = SSR_HW_RST;
		end
		// new events win over a clear in the same cycle
		next_st.esr = next_st.esr | evt_set;
		next_st.hardware_condition_register = next_st.hardware_condition_register | hw_set;

		// measurement done, set wins over clear
		if (meas_start || meas_clear)
		begin
			next_st.measurement_done_bit = 1'b0;
		end
		if (meas_done)
		begin
			next_st.measurement_done_bit = 1'b1;
		end

		// message available tracks the output buffer
		next_st.mav = out_buf_nonempty;

		if (spoll_req)
		begin
			next_st.rqs = 1'b0;
		end
		// rise of the master summary requests service
		if (mss_rise)
		begin
			next_st.rqs = 1'b1;
		end

		// poll answer carries RQS in bit 6
		if (spoll_req)
		begin
			next_st.spoll_valid = 1'b1;
			next_st.spoll_data = st.stb;
			next_st.spoll_data[SSR_STB_RQS] = st.rqs;
		end

		// addressing from the bus decoder
		if (unaddr)
		begin
			next_st.talk = 1'b0;
			next_st.listen = 1'b0;
		end
		if (addr_talk)
		begin
			next_st.talk = 1'b1;
			next_st.listen = 1'b0;
		end
		if (addr_listen)
		begin
			next_st.listen = 1'b1;
			next_st.talk = 1'b0;
		end
		// interface clear unaddresses, RQS and byte kept
		if (ifc_level)
		begin
			next_st.talk = 1'b0;
			next_st.listen = 1'b0;
		end

		// query answers, one cycle after the command
		if (cmd_valid)
		begin
			case (cmd_code)
				SSR_GET_EVT_EN:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = event_enable_mask;
				end
				// service enable query, bit 6 zero
				SSR_GET_SRQ_EN:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = {8'h00, service_request_mask};
				end
				SSR_GET_HW_EN:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = hardware_condition_enable;
				end
				SSR_GET_STB:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = {8'h00, st.stb};
				end
				SSR_GET_EVT_STAT:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = st.esr;
				end
				SSR_GET_HW_COND:
				begin
					next_st.resp_valid = 1'b1;
					next_st.resp_data = st.hardware_condition_register;
				end
				default:
				begin
					next_st.resp_valid = 1'b0;
				end
			endcase
		end

		// status byte image with the master summary in bit 6
		next_st.stb = stb_base;
		next_st.stb[SSR_STB_RQS] = mss;
	end

	// ============================================================
	// state register; power-on clears events and arms the restore
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.por_pending <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ============================================================
	// outputs, all from flip-flops
	assign resp_valid = st.resp_valid;
	assign resp_data = st.resp_data;
	assign spoll_valid = st.spoll_valid;
	assign spoll_data = st.spoll_data;
	assign talk_active = st.talk;
	assign listen_active = st.listen;
	assign srq_out = st.rqs;
	assign status_summary_byte = st.stb;

endmodule
`default_nettype wire

//--- inc/ssr_pkg.sv
// constants, command codes and status byte layout of the service request block
// Functional notes
// - event enable query returns its bit pattern
// - event enable write loads exact pattern
// - event enable clears on zero, or on power-on with the clear flag set
// - eight-bit status byte, fixed bit positions
// - master summary ORs enabled status bits
// - bit 5 summarises enabled event status
// - bit 0 summarises enabled hardware conditions
// - message available follows output buffer
// - measurement done sets, clears on restart
// - poll returns RQS, query returns summary
// - serial poll completion clears RQS
// - reading status byte changes no summary
// - clear status spares buffer, done, available
// - enabled summary raises a service request
// - service enable query, bit 6 zero
// - service enable write stores pattern, bit 6 dropped
// - service enable clears on zero, or on power-on with the clear flag set
// - interface clear unaddresses, keeps RQS, byte
// - event status read returns then clears
// - hardware condition read returns then clears
// - event enable is sixteen bits wide
`default_nettype none
package ssr_pkg;

	// register widths
	localparam int SSR_EVT_W = 16;
	localparam int SSR_HW_W = 16;
	localparam int SSR_STB_W = 8;
	localparam int SSR_RESP_W = 16;

	// status byte bit positions
	localparam int SSR_STB_HSB = 0;
	localparam int SSR_STB_MCB = 1;
	localparam int SSR_STB_MAV = 4;
	localparam int SSR_STB_ESB = 5;
	localparam int SSR_STB_RQS = 6;

	// writable bits of the service request mask: bit 6 never stored
	localparam logic [SSR_STB_W-1:0] SSR_SRE_KEEP = 8'hBF;
	localparam logic [SSR_EVT_W-1:0] SSR_EVT_KEEP = 16'hFFFF;
	localparam logic [SSR_HW_W-1:0] SSR_HW_KEEP = 16'hFFFF;

	// reset values
	localparam logic [SSR_EVT_W-1:0] SSR_EVT_RST = 16'h0000;
	localparam logic [SSR_HW_W-1:0] SSR_HW_RST = 16'h0000;
	localparam logic [SSR_STB_W-1:0] SSR_STB_RST = 8'h00;
	localparam logic [SSR_RESP_W-1:0] SSR_RESP_RST = 16'h0000;

	// commands from the message parser
	typedef enum logic [3:0] {
		SSR_SET_EVT_EN,
		SSR_GET_EVT_EN,
		SSR_SET_SRQ_EN,
		SSR_GET_SRQ_EN,
		SSR_SET_HW_EN,
		SSR_GET_HW_EN,
		SSR_GET_STB,
		SSR_GET_EVT_STAT,
		SSR_GET_HW_COND,
		SSR_CLR_STATUS
	} ssr_cmd_e;

endpackage
`default_nettype wire

//--- design/ssr_sync.sv
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
`default_nettype none
module ssr_sync
	import ssr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// pin side
	input wire logic pin_in,
	// filtered level
	output logic level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ssr_sync_s;

	ssr_sync_s st;
	ssr_sync_s next_st;

	// shift chain; the first stage feeds only the second
	always_comb
	begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3)
		begin
			next_st.lvl = st.s3;
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign level = st.lvl;

endmodule
`default_nettype wire

//--- design/ssr_mask_reg.sv
// enable mask register: command write, power-on restore or clear
`timescale 1ns/1ps
`default_nettype none
module ssr_mask_reg
	import ssr_pkg::*;
#(
	parameter int W = 16,
	parameter logic [W-1:0] KEEP = '1
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// command write
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	// power-on restore of the saved pattern
	input wire logic restore_en,
	input wire logic [W-1:0] restore_data,
	// stored mask
	output logic [W-1:0] value
);

	typedef struct packed {
		logic [W-1:0] mask;
	} ssr_mask_s;

	ssr_mask_s st;
	ssr_mask_s next_st;

	// a write of zero clears, any other value loads its pattern masked by KEEP
	always_comb
	begin
		next_st = st;
		if (wr_en)
		begin
			next_st.mask = wr_data & KEEP;
		end
		else if (restore_en)
		begin
			next_st.mask = restore_data & KEEP;
		end
	end

	// power-on leaves the mask clear until restore decides
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign value = st.mask;

endmodule
`default_nettype wire

//--- bench/ssr_ctrl_model.sv
// bus controller model that serial polls the instrument
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_model
#(
	parameter int WAIT = 3
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// bench control
	input wire logic poll_en,
	input wire logic poll_any,
	// instrument side
	input wire logic srq_out,
	output logic spoll_req
);
	int cnt = 0;
	logic busy = 1'b0;
	initial spoll_req = 1'b0;
	// one poll pulse
	// waits WAIT cycles so the answer comes slowly or promptly
	always @(posedge core_clk)
	begin
		spoll_req <= 1'b0;
		if (!resetn || !poll_en)
		begin
			cnt <= 0;
			busy <= 1'b0;
		end
		else if (!busy && (srq_out || poll_any))
		begin
			cnt <= cnt + 1;
			if (cnt == WAIT)
			begin
				spoll_req <= 1'b1;
				busy <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/ssr_top_chk.sv
// assertions on the status byte and service request ports
`timescale 1ns/1ps
`default_nettype none
module ssr_top_chk
	import ssr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// commands and polls
	input wire logic cmd_valid,
	input wire ssr_cmd_e cmd_code,
	input wire logic resp_valid,
	input wire logic spoll_req,
	input wire logic spoll_valid,
	input wire logic [SSR_STB_W-1:0] spoll_data,
	// events and pins
	input wire logic meas_done,
	input wire logic out_buf_nonempty,
	input wire logic ifc_pin,
	input wire logic talk_active,
	input wire logic listen_active,
	// status outputs
	input wire logic srq_out,
	input wire logic [SSR_STB_W-1:0] status_summary_byte
);
	// a query that must be answered
	wire logic is_get;
	assign is_get = cmd_valid && cmd_code inside {SSR_GET_EVT_EN,
		SSR_GET_SRQ_EN, SSR_GET_HW_EN, SSR_GET_STB, SSR_GET_EVT_STAT,
		SSR_GET_HW_COND};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ====================
	// answers and polls
	resp_timing_a: assert property (resp_valid == $past(is_get))
		else $error("query answer misplaced");
	poll_answer_a: assert property (spoll_valid == $past(spoll_req))
		else $error("poll answer misplaced");
	poll_rqs_a: assert property (spoll_valid |->
		spoll_data[6] == $past(srq_out)) else $error("poll bit 6 wrong");
	poll_clear_a: assert property (spoll_req &&
		!status_summary_byte[6] ##1 !status_summary_byte[6] |-> !srq_out)
		else $error("poll left request");
	// ====================
	// service request
	srq_raise_a: assert property ($rose(status_summary_byte[6]) &&
		!spoll_req |-> ##[0:2] srq_out) else $error("no request");
	srq_hold_a: assert property (srq_out && !spoll_req |=> srq_out)
		else $error("request dropped");
	// ====================
	// status byte bits and interface clear
	stb_unused_a: assert property ((status_summary_byte & 8'h8c) == 0)
		else $error("unused bit set");
	mav_empty_a: assert property (!out_buf_nonempty [*3] |=>
		!status_summary_byte[4]) else $error("available while empty");
	done_set_a: assert property (meas_done |->
		##[1:3] status_summary_byte[1]) else $error("done bit missing");
	ifc_drop_a: assert property (ifc_pin [*6] |->
		!talk_active && !listen_active) else $error("still addressed");
endmodule
bind ssr_top ssr_top_chk u_chk (.core_clk, .resetn, .cmd_valid, .cmd_code,
	.resp_valid, .spoll_req, .spoll_valid, .spoll_data, .meas_done,
	.out_buf_nonempty, .ifc_pin, .talk_active, .listen_active, .srq_out,
	.status_summary_byte);
`default_nettype wire

//--- bench/test_status_byte_service_request.sv
// self-checking bench of the status byte and service request block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module test_status_byte_service_request
	import ssr_pkg::*;
;
	logic core_clk = 1'b0, resetn = 1'b0, psc_flag = 1'b0;
	logic cmd_valid = 1'b0, out_buf_nonempty = 1'b0, ifc_pin = 1'b0;
	logic meas_done = 1'b0, meas_start = 1'b0, meas_clear = 1'b0;
	logic addr_talk = 1'b0, addr_listen = 1'b0, unaddr = 1'b0;
	logic poll_en = 1'b0, poll_any = 1'b0;
	ssr_cmd_e cmd_code = SSR_GET_STB;
	logic [15:0] cmd_data = 16'h0000, evt_set = 16'h0000;
	logic [15:0] hw_set = 16'h0000, saved_evt_en = 16'h0000;
	logic [15:0] saved_hw_en = 16'h0000, resp_data, got, ex;
	logic [7:0] saved_srq_en = 8'h00, spoll_data, status_summary_byte;
	logic resp_valid, spoll_valid, spoll_req, srq_out;
	logic talk_active, listen_active;
	logic [15:0] exp_q[$];
	logic [31:0] rs = 32'hbe55_4734;
	int fail_count = 0;
	int n_tests = 0;
	always #2.5 core_clk = ~core_clk;
	ssr_top uut (.core_clk, .resetn, .psc_flag, .saved_evt_en, .saved_srq_en,
		.saved_hw_en, .cmd_valid, .cmd_code, .cmd_data, .resp_valid,
		.resp_data, .evt_set, .hw_set, .meas_done, .meas_start, .meas_clear,
		.out_buf_nonempty, .spoll_req, .spoll_valid, .spoll_data, .addr_talk,
		.addr_listen, .unaddr, .ifc_pin, .talk_active, .listen_active,
		.srq_out, .status_summary_byte);
	ssr_ctrl_model #(.WAIT(3)) ctrl (.core_clk, .resetn, .poll_en, .poll_any,
		.srq_out, .spoll_req);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmd(input ssr_cmd_e c, input logic [15:0] d);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic get(input ssr_cmd_e c, input logic [15:0] e);
		exp_q.push_back(e);
		cmd(c, 16'h0000);
		repeat (2) @(posedge core_clk);
	endtask
	task automatic ev(input logic [15:0] e, h, input logic [2:0] m);
		@(posedge core_clk);
		evt_set <= e;
		hw_set <= h;
		{meas_done, meas_start, meas_clear} <= m;
		@(posedge core_clk);
		evt_set <= 16'h0000;
		hw_set <= 16'h0000;
		{meas_done, meas_start, meas_clear} <= 3'b000;
	endtask
	task automatic ad(input logic [2:0] a);
		@(posedge core_clk);
		{addr_talk, addr_listen, unaddr} <= a;
		@(posedge core_clk);
		{addr_talk, addr_listen, unaddr} <= 3'b000;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic sb(input logic [7:0] e);
		repeat (4) @(posedge core_clk);
		`CHK(status_summary_byte, e)
	endtask
	task automatic poll(input logic a, input logic [15:0] e);
		exp_q.push_back(e);
		poll_en <= 1'b1;
		poll_any <= a;
		repeat (10) @(posedge core_clk);
		poll_en <= 1'b0;
	endtask
	task automatic rst(input logic p);
		@(posedge core_clk);
		resetn <= 1'b0;
		psc_flag <= p;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// compares every answer with the oldest note
	always @(posedge core_clk)
	begin
		if (resp_valid === 1'b1 || spoll_valid === 1'b1)
		begin
			got = resp_valid ? resp_data : {8'h00, spoll_data};
			ex = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
			`CHK(got, ex)
		end
	end
	// watchdog
	initial
	begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		end_sim();
	end
	// main sequence
	initial
	begin
		logic [15:0] d;
		rs = nx(rs);
		saved_evt_en <= rs[15:0];
		saved_srq_en <= rs[23:16];
		saved_hw_en <= rs[31:16];
		rst(1'b0);
		get(SSR_GET_EVT_EN, saved_evt_en);
		get(SSR_GET_SRQ_EN, {8'h00, saved_srq_en & 8'hbf});
		get(SSR_GET_HW_EN, saved_hw_en);
		rst(1'b1);
		get(SSR_GET_EVT_EN, 16'h0000);
		get(SSR_GET_SRQ_EN, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			rs = nx(rs);
			d = (i == 0) ? 16'h0000 : rs[15:0];
			cmd(SSR_SET_EVT_EN, d);
			get(SSR_GET_EVT_EN, d);
			cmd(SSR_SET_SRQ_EN, d | 16'h0040);
			get(SSR_GET_SRQ_EN, {8'h00, d[7:0] & 8'hbf});
			cmd(SSR_SET_HW_EN, ~d);
			get(SSR_GET_HW_EN, ~d);
		end
		cmd(SSR_SET_EVT_EN, 16'h0024);
		cmd(SSR_SET_SRQ_EN, 16'h0020);
		cmd(SSR_SET_HW_EN, 16'h0044);
		ev(16'h0004, 16'h0000, 3'b000);
		sb(8'h60);
		`CHK(srq_out, 1'b1)
		get(SSR_GET_STB, 16'h0060);
		poll(1'b0, 16'h0060);
		`CHK(srq_out, 1'b0)
		sb(8'h60);
		poll(1'b1, 16'h0020);
		get(SSR_GET_EVT_STAT, 16'h0004);
		sb(8'h00);
		get(SSR_GET_EVT_STAT, 16'h0000);
		ev(16'h0000, 16'h0004, 3'b000);
		sb(8'h01);
		get(SSR_GET_HW_COND, 16'h0004);
		sb(8'h00);
		cmd(SSR_SET_SRQ_EN, 16'h0010);
		out_buf_nonempty <= 1'b1;
		sb(8'h50);
		`CHK(srq_out, 1'b1)
		ev(16'h0004, 16'h0004, 3'b100);
		sb(8'h73);
		cmd(SSR_CLR_STATUS, 16'h0000);
		sb(8'h52);
		// talk and listen pulses together: listen is applied last
		ad(3'b110);
		`CHK({talk_active, listen_active}, 2'b01)
		ifc_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		`CHK({talk_active, listen_active, srq_out}, 3'b001)
		sb(8'h52);
		ifc_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		ad(3'b100);
		`CHK({talk_active, listen_active}, 2'b10)
		ad(3'b001);
		`CHK(talk_active, 1'b0)
		ev(16'h0000, 16'h0000, 3'b001);
		sb(8'h50);
		ev(16'h0000, 16'h0000, 3'b100);
		sb(8'h52);
		ev(16'h0000, 16'h0000, 3'b010);
		sb(8'h50);
		out_buf_nonempty <= 1'b0;
		sb(8'h00);
		// request still pending while the summary is low
		poll(1'b0, 16'h0040);
		`CHK(srq_out, 1'b0)
		end_sim();
	end
endmodule
`default_nettype wire
